// ==== inc/sls_defines.vh ====
`ifndef SLS_DEFINES_VH
`define SLS_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SLS_OFF_CTRL 8'h00
`define SLS_OFF_CLEAR 8'h04
`define SLS_OFF_STATUS 8'h08
`define SLS_OFF_LADDR 8'h0C
`define SLS_OFF_LDATA 8'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SLS_CTRL_RUN 0
`define SLS_CTRL_DIV 1
`define SLS_CTRL_MODE_LO 4
`define SLS_CTRL_MODE_HI 5
`define SLS_CTRL_LAST_LO 16
`define SLS_CTRL_LAST_HI 24
`define SLS_CLEAR_BIT 0

// ----------------------------------------
// acquisition modes
// ----------------------------------------
`define SLS_MODE_SINGLE 2'h0
`define SLS_MODE_CONT 2'h1
`define SLS_MODE_INTERVAL 2'h2

// ----------------------------------------
// status register fields
// ----------------------------------------
`define SLS_STAT_RUN 0
`define SLS_STAT_WAIT 1
`define SLS_STAT_PTR_LO 16
`define SLS_STAT_PTR_HI 24

// ----------------------------------------
// list entry layout
// ----------------------------------------
`define SLS_ENTRY_W 9
`define SLS_CHAN_LO 0
`define SLS_CHAN_HI 3
`define SLS_GAIN_LO 4
`define SLS_GAIN_HI 6
`define SLS_SYNC_BIT 7
`define SLS_LAST_BIT 8
`define SLS_DEPTH 512
`define SLS_AW 9
`define SLS_CTRL_RST 32'h0000_0000

`endif

// ==== verilog/sls_list_mem.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"

// ----------------------------------------
// scan list storage: one write port, two registered read ports
// ----------------------------------------
module sls_list_mem #(
  parameter DEPTH = `SLS_DEPTH,
  parameter AW = `SLS_AW,
  parameter DW = `SLS_ENTRY_W
) (
  input wire clk_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [DW-1:0] wdata_i,
  input wire [AW-1:0] seq_addr_i,
  output reg [DW-1:0] seq_data_o,
  input wire [AW-1:0] sw_addr_i,
  output reg [DW-1:0] sw_data_o
);

  reg [DW-1:0] mem_r [0:DEPTH-1];

  // no reset on the array: contents are undefined until software loads them
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    seq_data_o <= mem_r[seq_addr_i];
    sw_data_o <= mem_r[sw_addr_i];
  end

endmodule // sls_list_mem

`default_nettype wire

// ==== verilog/sls_sequencer.v ====
// Operation
// - single mode keeps channel and gain fixed
// - list memory holds 512 pointer-addressed entries
// - entry: channel, gain, sync, last-entry bits
// - selected entry drives channel and gain outputs
// - pointer steps entries on each advance clock
// - interval list may hold many sequences
// - conversion pulse from interval counter, driven out
// - single mode disables the advance clock
// - undivided scan: advance equals conversion pulse
// - divided scan: external divider drives advance
// - next entry applied right after conversion starts
// - continuous scan wraps with no pause
// - interval scan pauses after each sequence
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"

module sls_sequencer #(
  parameter DEPTH = `SLS_DEPTH,
  parameter AW = `SLS_AW
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // timing partners
  input wire sample_tick_i,
  input wire divided_advance_i,
  input wire interval_tick_i,
  // front end
  output reg scan_conversion_pulse_o,
  output reg list_advance_clock_o,
  output reg [3:0] channel_o,
  output reg [2:0] gain_o,
  output reg sync_o,
  output reg last_entry_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [31:0] ctrl_r;
  reg [31:0] ctrl_nxt;
  reg running_r;
  reg running_nxt;
  reg waiting_r;
  reg waiting_nxt;
  reg [AW-1:0] ptr_r;
  reg [AW-1:0] ptr_nxt;
  reg [AW-1:0] laddr_r;
  reg [AW-1:0] laddr_nxt;
  reg [31:0] rdata_nxt;
  reg adv_nxt;
  reg pulse_nxt;
  reg mem_we;
  reg clear_req;
  reg start_req;
  wire req;
  wire wr;
  wire rd;
  wire [1:0] mode;
  wire div_en;
  wire [AW-1:0] last_idx;
  wire [`SLS_ENTRY_W-1:0] seq_entry;
  wire [`SLS_ENTRY_W-1:0] sw_entry;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // ack the cycle after the request is seen, then drop it for one cycle;
  // a write commits on the edge that samples ack, where the master ends it
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  assign rd = req & ~wb_we_i;

  assign mode = ctrl_r[`SLS_CTRL_MODE_HI:`SLS_CTRL_MODE_LO];
  assign div_en = ctrl_r[`SLS_CTRL_DIV];
  assign last_idx = ctrl_r[`SLS_CTRL_LAST_HI:`SLS_CTRL_LAST_LO];

  // ----------------------------------------
  // list memory
  // ----------------------------------------
  sls_list_mem #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(`SLS_ENTRY_W)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(laddr_r),
    .wdata_i(wb_dat_i[`SLS_ENTRY_W-1:0]),
    .seq_addr_i(ptr_r),
    .seq_data_o(seq_entry),
    .sw_addr_i(laddr_r),
    .sw_data_o(sw_entry)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @* begin
    ctrl_nxt = ctrl_r;
    laddr_nxt = laddr_r;
    mem_we = 1'b0;
    clear_req = 1'b0;
    start_req = 1'b0;
    if (wr && wb_adr_i == `SLS_OFF_CTRL) begin
      if (wb_sel_i[0]) begin
        ctrl_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ctrl_nxt[15:8] = wb_dat_i[15:8];
      end
      if (wb_sel_i[2]) begin
        ctrl_nxt[23:16] = wb_dat_i[23:16];
      end
      if (wb_sel_i[3]) begin
        ctrl_nxt[31:24] = wb_dat_i[31:24];
      end
      ctrl_nxt[31:`SLS_CTRL_LAST_HI+1] = 7'h00;
      ctrl_nxt[15:`SLS_CTRL_MODE_HI+1] = 10'h000;
      ctrl_nxt[3:2] = 2'h0;
      start_req = ~ctrl_r[`SLS_CTRL_RUN] & ctrl_nxt[`SLS_CTRL_RUN];
    end else if (wr && wb_adr_i == `SLS_OFF_CLEAR) begin
      clear_req = wb_sel_i[0] & wb_dat_i[`SLS_CLEAR_BIT];
    end else if (wr && wb_adr_i == `SLS_OFF_LADDR) begin
      if (wb_sel_i[0]) begin
        laddr_nxt[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        laddr_nxt[AW-1:8] = wb_dat_i[AW-1:8];
      end
    end else if (wr && wb_adr_i == `SLS_OFF_LDATA) begin
      // loading while a scan is active is the caller's hazard, not refused
      // an entry spans the two low byte lanes
      mem_we = wb_sel_i[0] & wb_sel_i[1];
      laddr_nxt = laddr_r + 1'b1;
    end
    if (clear_req) begin
      ctrl_nxt[`SLS_CTRL_RUN] = 1'b0;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // unmapped offsets read as zero and still get an ack
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (wb_adr_i == `SLS_OFF_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (wb_adr_i == `SLS_OFF_STATUS) begin
      rdata_nxt[`SLS_STAT_RUN] = running_r;
      rdata_nxt[`SLS_STAT_WAIT] = waiting_r;
      rdata_nxt[`SLS_STAT_PTR_HI:`SLS_STAT_PTR_LO] = ptr_r;
    end else if (wb_adr_i == `SLS_OFF_LADDR) begin
      rdata_nxt[AW-1:0] = laddr_r;
    end else if (wb_adr_i == `SLS_OFF_LDATA) begin
      rdata_nxt[`SLS_ENTRY_W-1:0] = sw_entry;
    end
  end

  // ----------------------------------------
  // conversion pulse and advance clock
  // ----------------------------------------
  always @* begin
    // no conversions are issued while an interval pause is pending
    pulse_nxt = running_r & ~waiting_r & sample_tick_i;
    adv_nxt = 1'b0;
    if (running_r && mode != `SLS_MODE_SINGLE) begin
      if (div_en) begin
        adv_nxt = divided_advance_i & ~waiting_r;
      end else begin
        adv_nxt = pulse_nxt;
      end
    end
  end

  // ----------------------------------------
  // pointer sequencing
  // ----------------------------------------
  always @* begin
    ptr_nxt = ptr_r;
    running_nxt = running_r;
    waiting_nxt = waiting_r;
    if (clear_req) begin
      ptr_nxt = {AW{1'b0}};
      running_nxt = 1'b0;
      waiting_nxt = 1'b0;
    end else if (start_req) begin
      ptr_nxt = {AW{1'b0}};
      running_nxt = 1'b1;
      waiting_nxt = 1'b0;
    end else if (wr && wb_adr_i == `SLS_OFF_CTRL && !ctrl_nxt[`SLS_CTRL_RUN]) begin
      running_nxt = 1'b0;
      waiting_nxt = 1'b0;
    end else if (running_r) begin
      if (waiting_r && interval_tick_i) begin
        waiting_nxt = 1'b0;
      end
      if (adv_nxt) begin
        // step on the same edge the advance clock goes out, which is the conversion pulse edge when undivided
        if (ptr_r == last_idx) begin
          ptr_nxt = {AW{1'b0}};
        end else begin
          ptr_nxt = ptr_r + 1'b1;
        end
        if (mode == `SLS_MODE_INTERVAL && seq_entry[`SLS_LAST_BIT]) begin
          waiting_nxt = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `SLS_CTRL_RST;
      laddr_r <= {AW{1'b0}};
      ptr_r <= {AW{1'b0}};
      running_r <= 1'b0;
      waiting_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      scan_conversion_pulse_o <= 1'b0;
      list_advance_clock_o <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      laddr_r <= laddr_nxt;
      ptr_r <= ptr_nxt;
      running_r <= running_nxt;
      waiting_r <= waiting_nxt;
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= rdata_nxt;
      end
      scan_conversion_pulse_o <= pulse_nxt;
      list_advance_clock_o <= adv_nxt;
    end
  end

  // ----------------------------------------
  // front end selection
  // ----------------------------------------
  // the memory read adds a cycle, so the new selection lands two cycles
  // after the advance clock (the conversion pulse when undivided), well inside the conversion time
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_o <= 4'h0;
      gain_o <= 3'h0;
      sync_o <= 1'b0;
      last_entry_o <= 1'b0;
    end else begin
      channel_o <= seq_entry[`SLS_CHAN_HI:`SLS_CHAN_LO];
      gain_o <= seq_entry[`SLS_GAIN_HI:`SLS_GAIN_LO];
      sync_o <= seq_entry[`SLS_SYNC_BIT];
      last_entry_o <= seq_entry[`SLS_LAST_BIT];
      // single mode never moves ptr_r, so the selection holds all run
    end
  end

endmodule // sls_sequencer

`default_nettype wire

// ==== verification/sls_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module sls_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sample_tick_i,
  input wire logic divided_advance_i,
  input wire logic scan_conversion_pulse_o,
  input wire logic list_advance_clock_o,
  input wire logic [3:0] channel_o,
  input wire logic [2:0] gain_o,
  input wire logic sync_o,
  input wire logic last_entry_o
);
  logic [1:0] adv_h;
  logic [2:0] ack_h;
  logic [2:0] rst_h;
  logic moved_ok;
  assign moved_ok = |{adv_h, ack_h[2:1], rst_h};
  // selection lags its cause by pointer, memory and output flop
  always @(posedge clk_i) begin
    adv_h <= {adv_h[0], list_advance_clock_o};
    ack_h <= {ack_h[1:0], wb_ack_o};
    rst_h <= {rst_h[1:0], rst_i};
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  pulse_src_a: assert property (scan_conversion_pulse_o |-> $past(sample_tick_i))
    else $error("pulse without tick");
  adv_src_a: assert property (
    list_advance_clock_o |-> scan_conversion_pulse_o || $past(divided_advance_i))
    else $error("advance without cause");
  sel_hold_a: assert property (!$stable({channel_o, gain_o, last_entry_o}) |-> moved_ok)
    else $error("selection moved without cause");
  sync_hold_a: assert property (!$stable(sync_o) |-> moved_ok)
    else $error("sync bit moved without cause");
  reset_zero_a: assert property (
    disable iff (1'h0) rst_i |=> !wb_ack_o && !list_advance_clock_o && channel_o == 4'h0)
    else $error("outputs active after reset");
  cover property (list_advance_clock_o && last_entry_o);
  cover property (list_advance_clock_o && !scan_conversion_pulse_o);
  cover property (scan_conversion_pulse_o);
endmodule // sls_sva
bind sls_sequencer sls_sva u_sva (.*);
`default_nettype wire

// ==== verification/sls_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module sls_partner #(parameter int PER = 4, parameter int DIVN = 3) (
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic pulse_i,
  output logic tick_o,
  output logic div_o
);
  int t = 0;
  int n = 0;
  initial tick_o = 1'h0;
  initial div_o = 1'h0;
  // divider counts the pulses the block really made, not the ticks
  always @(posedge clk_i) begin
    t <= en_i ? (t + 1) % PER : 0;
    tick_o <= en_i && t == PER - 1;
    n <= pulse_i ? (n + 1) % DIVN : n;
    div_o <= pulse_i && n == DIVN - 1;
  end
endmodule // sls_partner
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sls_defines.vh"
module tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic interval_tick_i = 1'h0;
  logic ten = 1'h0;
  logic wb_ack_o, sample_tick_i, divided_advance_i, scan_conversion_pulse_o;
  logic list_advance_clock_o, sync_o, last_entry_o;
  logic [3:0] channel_o;
  logic [2:0] gain_o;
  logic [31:0] wb_dat_o, q;
  int fails, comparisons, n, nt, nd, np, na, t0, d0, p0, a0, e;
  always #2.5 clk_i = ~clk_i;
  sls_sequencer uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .sample_tick_i(sample_tick_i),
    .divided_advance_i(divided_advance_i),
    .interval_tick_i(interval_tick_i),
    .scan_conversion_pulse_o(scan_conversion_pulse_o),
    .list_advance_clock_o(list_advance_clock_o),
    .channel_o(channel_o),
    .gain_o(gain_o),
    .sync_o(sync_o),
    .last_entry_o(last_entry_o)
  );
  sls_partner #(.PER(4), .DIVN(3)) u_ptn (.clk_i(clk_i), .en_i(ten), .pulse_i(scan_conversion_pulse_o),
    .tick_o(sample_tick_i), .div_o(divided_advance_i));
  // ------
  // event counts and hang guard
  // ------
  always @(posedge clk_i) begin
    n <= n + 1;
    nt <= nt + sample_tick_i;
    nd <= nd + divided_advance_i;
    np <= np + scan_conversion_pulse_o;
    na <= na + list_advance_clock_o;
    if (n == 5000) begin
      fails++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] v, input logic [31:0] x);
    comparisons++;
    if (v !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, x, v);
    end
  endtask
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task rs(input logic [31:0] x);
    wb(`SLS_OFF_STATUS, 1'h0, 32'h0);
    chk("status", q, x);
  endtask
  // a fresh start always passes through clear so run goes 0 to 1
  task st(input logic [31:0] c);
    wb(`SLS_OFF_CLEAR, 1'h1, 32'h1);
    wb(`SLS_OFF_CTRL, 1'h1, c);
    t0 = nt;
    d0 = nd;
    p0 = np;
    a0 = na;
  endtask
  task run(input int c);
    ten <= 1'h1;
    repeat (c) @(posedge clk_i);
    ten <= 1'h0;
    repeat (12) @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rs(32'h0);
    wb(8'h20, 1'h0, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(`SLS_OFF_LADDR, 1'h1, 32'h1FF);
    wb(`SLS_OFF_LDATA, 1'h1, 32'h5A);
    wb(`SLS_OFF_LADDR, 1'h1, 32'h0);
    for (int i = 0; i < 8; i++)
      wb(`SLS_OFF_LDATA, 1'h1, {23'h0, i[1:0] == 2'h3, i[0], i[2:0], 4'hF - i[3:0]});
    wb(`SLS_OFF_LADDR, 1'h1, 32'h1FF);
    wb(`SLS_OFF_LDATA, 1'h0, 32'h0);
    chk("top entry", q, 32'h5A);
    $display("list load done");
    st(32'h0007_0001);
    run(40);
    rs(32'h1);
    chk("single advances", na - a0, 0);
    chk("single pulses", np - p0, nt - t0);
    chk("single select", {last_entry_o, sync_o, gain_o, channel_o}, 9'h00F);
    $display("single test done");
    st(32'h0007_0011);
    run(62);
    e = (nt - t0) % 8;
    rs((e << 16) | 1);
    chk("scan advances", na - a0, nt - t0);
    chk("scan select", {sync_o, gain_o, channel_o}, {e[0], e[2:0], 4'hF - e[3:0]});
    $display("continuous test done");
    st(32'h0007_0013);
    run(62);
    e = (nd - d0) % 8;
    rs((e << 16) | 1);
    chk("divided advances", na - a0, nd - d0);
    $display("divided test done");
    st(32'h0007_0021);
    run(62);
    rs(32'h0004_0003);
    chk("wait select", {last_entry_o, channel_o}, 5'h0B);
    interval_tick_i <= 1'h1;
    @(posedge clk_i);
    interval_tick_i <= 1'h0;
    run(62);
    rs(32'h3);
    chk("interval pulses", np - p0, 8);
    $display("interval test done");
    wb(`SLS_OFF_CLEAR, 1'h1, 32'h1);
    rs(32'h0);
    $display("clear test done");
    give_verdict;
  end
endmodule // tb
`default_nettype wire
